// ===== hw/ecl_loader.sv
/*
  configuration loader: mode strap capture, eeprom fetch as bus master,
  load-complete pin, and a filtered secondary snoop of the bus pins.
  assumes the bus wires are open drain, resolved outside; pins async.
*/
// Overview of operation
// - primary mode masters bus, reads eeprom
// - good read drives done output low
// - done about 30 ms after load request
// - secondary path answers in every stage
// - filter bus glitches up to 50 ns
// - master scl 1.9 us low, 1.4 high
// - straps sampled once after each reset release
// - secondary bus runs up to 400 kHz
`timescale 1ns/100ps
module ecl_loader
#(
  parameter int LOAD_CYC   = ecl_pkg::LOAD_CYC,
  parameter int LOAD_BYTES = 16
)
(
  // clock and reset
  input  wire logic             I_CLK,
  input  wire logic             I_RST_N,
  // straps and control
  input  wire logic [2:0]       I_MODE_STRAP,
  input  wire logic             I_LOAD_REQ_N,
  output      logic             O_LOAD_DONE_N,
  output      logic             O_PRIMARY,
  // bus pins, level in and drive enable out
  input  wire logic             I_SCL,
  input  wire logic             I_SDA,
  output      logic             O_SCL_OE_N,
  output      logic             O_SDA_OE_N,
  // secondary side: filtered bus levels for the register decoder
  output      logic             O_SCL_FILT,
  output      logic             O_SDA_FILT,
  // fetched configuration bytes
  output      logic [7:0]       O_CFG_DATA,
  output      logic             O_CFG_VALID
);

  typedef struct packed {
    logic [1:0]        scl_sy;
    logic [1:0]        sda_sy;
    logic [1:0]        req_sy;
    logic              scl_f;
    logic              sda_f;
    logic [3:0]        scl_cnt;
    logic [3:0]        sda_cnt;
    logic              strapped;
    logic [1:0][2:0]   strap_sy;
    logic [1:0]        strap_age;
    logic              primary;
    ecl_pkg::ecl_state_t st;
    logic [7:0]        ph_cnt;
    logic              scl_drv_low;
    logic              sda_drv_low;
    logic [8:0]        sh;
    logic [3:0]        bit_idx;
    logic [7:0]        byte_idx;
    logic [1:0]        phase;
    logic              done_n;
    logic [31:0]       load_cnt;
    logic [7:0]        cfg;
    logic              cfg_vld;
  } ecl_reg_t;

  ecl_reg_t r_ff;
  ecl_reg_t nxt_r;

  // serial sequence: addr+r is 8 bits and ack, then data bytes
  function automatic logic [8:0] addr_word();
    return {ecl_pkg::EEPROM_ADDR, 1'b1, 1'b1};
  endfunction

  always_comb
  begin
    nxt_r = r_ff;
    nxt_r.cfg_vld = 1'b0;
    nxt_r.scl_sy = {r_ff.scl_sy[0], I_SCL};
    nxt_r.sda_sy = {r_ff.sda_sy[0], I_SDA};
    nxt_r.req_sy = {r_ff.req_sy[0], I_LOAD_REQ_N};

    // level must differ for longer than the spike width to be taken
    if (r_ff.scl_sy[1] == r_ff.scl_f)
      nxt_r.scl_cnt = 4'h0;
    else if (32'(r_ff.scl_cnt) >= ecl_pkg::SPIKE_CYC)
    begin
      nxt_r.scl_f = r_ff.scl_sy[1];
      nxt_r.scl_cnt = 4'h0;
    end
    else
      nxt_r.scl_cnt = r_ff.scl_cnt + 4'h1;
    if (r_ff.sda_sy[1] == r_ff.sda_f)
      nxt_r.sda_cnt = 4'h0;
    else if (32'(r_ff.sda_cnt) >= ecl_pkg::SPIKE_CYC)
    begin
      nxt_r.sda_f = r_ff.sda_sy[1];
      nxt_r.sda_cnt = 4'h0;
    end
    else
      nxt_r.sda_cnt = r_ff.sda_cnt + 4'h1;

    // strap caught once after reset release, then frozen; the pins pass
    // a two-stage synchroniser, so capture waits for it to fill
    nxt_r.strap_sy = {r_ff.strap_sy[0], I_MODE_STRAP};
    if (!r_ff.strapped)
    begin
      if (r_ff.strap_age == 2'h2)
      begin
        nxt_r.strapped = 1'b1;
        nxt_r.primary = (r_ff.strap_sy[1] == ecl_pkg::STRAP_LEVEL_ONE);
      end
      else
        nxt_r.strap_age = r_ff.strap_age + 2'h1;
    end

    if (r_ff.load_cnt != 32'h0)
      nxt_r.load_cnt = r_ff.load_cnt - 32'h1;

    unique case (r_ff.st)
      ecl_pkg::ECL_IDLE:
      begin
        // start on load request; the typical load delay is counted from here
        if (r_ff.strapped && r_ff.primary && !r_ff.req_sy[1])
        begin
          nxt_r.st = ecl_pkg::ECL_START;
          nxt_r.load_cnt = 32'(LOAD_CYC);
          nxt_r.ph_cnt = 8'h0;
        end
      end
      ecl_pkg::ECL_START:
      begin
        // sda falls while scl high; another master owning the bus waits
        nxt_r.ph_cnt = r_ff.ph_cnt + 8'h1;
        if (r_ff.ph_cnt == 8'h0 && !r_ff.sda_f)
          nxt_r.ph_cnt = 8'h0;
        else if (32'(r_ff.ph_cnt) == ecl_pkg::SCL_HIGH_CYC)
          nxt_r.sda_drv_low = 1'b1;
        else if (32'(r_ff.ph_cnt) == 2 * ecl_pkg::SCL_HIGH_CYC)
        begin
          nxt_r.scl_drv_low = 1'b1;
          nxt_r.sh = addr_word();
          nxt_r.bit_idx = 4'h0;
          nxt_r.byte_idx = 8'h0;
          nxt_r.phase = 2'h0;
          nxt_r.ph_cnt = 8'h0;
          nxt_r.st = ecl_pkg::ECL_BIT;
        end
      end
      ecl_pkg::ECL_BIT:
      begin
        nxt_r.ph_cnt = r_ff.ph_cnt + 8'h1;
        if (r_ff.phase == 2'h0 && 32'(r_ff.ph_cnt) == 1)
          nxt_r.sda_drv_low = !r_ff.sh[8];
        if (r_ff.phase == 2'h0 &&
            32'(r_ff.ph_cnt) == ecl_pkg::SCL_LOW_CYC - 1)
        begin
          nxt_r.scl_drv_low = 1'b0;
          nxt_r.ph_cnt = 8'h0;
          nxt_r.phase = 2'h1;
        end
        else if (r_ff.phase == 2'h1 && !r_ff.scl_f)
          nxt_r.ph_cnt = 8'h0; // clock stretched by the far end
        else if (r_ff.phase == 2'h1 &&
                 32'(r_ff.ph_cnt) == ecl_pkg::SCL_HIGH_CYC - 1)
        begin
          nxt_r.scl_drv_low = 1'b1;
          nxt_r.ph_cnt = 8'h0;
          nxt_r.phase = 2'h0;
          nxt_r.sh = {r_ff.sh[7:0], r_ff.sda_f};
          nxt_r.bit_idx = r_ff.bit_idx + 4'h1;
          // lost arbitration: released high but bus low
          if (r_ff.sh[8] && !r_ff.sda_f && r_ff.bit_idx != 4'h8 &&
              (r_ff.byte_idx == 8'h0 || r_ff.bit_idx == 4'h8))
            nxt_r.st = ecl_pkg::ECL_FAIL;
          if (r_ff.bit_idx == 4'h8)
          begin
            if (r_ff.byte_idx == 8'h0 && r_ff.sda_f)
              nxt_r.st = ecl_pkg::ECL_FAIL;
            if (r_ff.byte_idx != 8'h0)
            begin
              nxt_r.cfg = r_ff.sh[7:0];
              nxt_r.cfg_vld = 1'b1;
            end
            nxt_r.bit_idx = 4'h0;
            nxt_r.byte_idx = r_ff.byte_idx + 8'h1;
            // master acks every byte but the last
            nxt_r.sh = {8'hff,
                        32'(r_ff.byte_idx) + 1 == LOAD_BYTES};
            if (32'(r_ff.byte_idx) == LOAD_BYTES)
              nxt_r.st = ecl_pkg::ECL_STOP;
          end
          // an aborted transfer leaves scl released rather than cut a
          // low phase short
          if (nxt_r.st == ecl_pkg::ECL_FAIL)
            nxt_r.scl_drv_low = 1'b0;
        end
      end
      ecl_pkg::ECL_STOP:
      begin
        nxt_r.ph_cnt = r_ff.ph_cnt + 8'h1;
        if (32'(r_ff.ph_cnt) == 1)
          nxt_r.sda_drv_low = 1'b1;
        else if (32'(r_ff.ph_cnt) == ecl_pkg::SCL_LOW_CYC)
          nxt_r.scl_drv_low = 1'b0;
        else if (32'(r_ff.ph_cnt) >=
                 ecl_pkg::SCL_LOW_CYC + ecl_pkg::SCL_HIGH_CYC)
        begin
          nxt_r.sda_drv_low = 1'b0;
          nxt_r.st = ecl_pkg::ECL_DONE;
        end
      end
      ecl_pkg::ECL_DONE:
      begin
        if (r_ff.load_cnt == 32'h0)
          nxt_r.done_n = 1'b0;
      end
      ecl_pkg::ECL_FAIL:
      begin
        nxt_r.scl_drv_low = 1'b0;
        nxt_r.sda_drv_low = 1'b0;
        nxt_r.done_n = 1'b1;
      end
      default:
        nxt_r.st = ecl_pkg::ECL_FAIL;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      r_ff <= '0;
      r_ff.scl_sy <= 2'h3;
      r_ff.sda_sy <= 2'h3;
      r_ff.req_sy <= 2'h3;
      r_ff.scl_f <= 1'b1;
      r_ff.sda_f <= 1'b1;
      r_ff.st <= ecl_pkg::ECL_IDLE;
      r_ff.done_n <= 1'b1;
      r_ff.cfg <= ecl_pkg::RESET_CFG;
    end
    else
      r_ff <= nxt_r;
  end

  // secondary path stays live in every loader state
  assign O_SCL_FILT    = r_ff.scl_f;
  assign O_SDA_FILT    = r_ff.sda_f;
  assign O_SCL_OE_N    = !r_ff.scl_drv_low;
  assign O_SDA_OE_N    = !r_ff.sda_drv_low;
  assign O_LOAD_DONE_N = r_ff.done_n;
  assign O_PRIMARY     = r_ff.primary;
  assign O_CFG_DATA    = r_ff.cfg;
  assign O_CFG_VALID   = r_ff.cfg_vld;

endmodule // ecl_loader

// ===== hw/ecl_pkg.sv
/*
  package of the configuration loader: timing counts, strap levels,
  loader states and an open-drain pin struct.
  assumes a 25 MHz core clock.
*/
package ecl_pkg;

  localparam int CLK_HZ = 25000000;

  // spike filter: 50 ns is the longest spike to drop; rounds up, since a
  // spike a little over one period can still land on two samples
  localparam int SPIKE_NS         = 50;
  localparam int SPIKE_CYC_RAW    =
    (SPIKE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int SPIKE_CYC        = (SPIKE_CYC_RAW < 1) ? 1 : SPIKE_CYC_RAW;

  // primary scl phases in ns: least times, round up
  localparam int SCL_LOW_NS       = 1900;
  localparam int SCL_HIGH_NS      = 1400;
  localparam int SCL_LOW_CYC      =
    (SCL_LOW_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int SCL_HIGH_CYC     =
    (SCL_HIGH_NS * (CLK_HZ / 1000000) + 999) / 1000;

  // typical eeprom load time, in ms
  localparam int LOAD_MS          = 30;
  localparam int LOAD_CYC         = LOAD_MS * (CLK_HZ / 1000);

  // strap level codes of the mode pin
  localparam logic [2:0] STRAP_LEVEL_ONE = 3'h1;
  localparam logic [2:0] STRAP_LEVEL_TWO = 3'h2;

  localparam logic [6:0] EEPROM_ADDR     = 7'h50;
  localparam logic [7:0] RESET_CFG       = 8'h00;

  typedef enum logic [2:0] {
    ECL_IDLE  = 3'b000,
    ECL_START = 3'b001,
    ECL_BIT   = 3'b010,
    ECL_STOP  = 3'b011,
    ECL_DONE  = 3'b100,
    ECL_FAIL  = 3'b101
  } ecl_state_t;

  // one open-drain pin: input, output level, enable (low = driving)
  typedef struct packed {
    logic i;
    logic o;
    logic oe_n;
  } ecl_pin_t;

endpackage

// ===== tb/ecl_eeprom_model.sv
/* eeprom model answering reads on the bus.
   assumes wired-and pull-up bus resolved outside. */
`timescale 1ns/100ps
module ecl_eeprom_model
(
  input  wire logic        scl,
  input  wire logic        sda,
  input  wire logic [15:0] data,
  input  wire logic        nak,
  output      logic        sda_oe_n
);
  int   r;
  logic busy;
  initial sda_oe_n = 1'b1;
  initial busy = 1'b0;
  always @(negedge sda) if (scl) begin busy = 1'b1; r = 0; end
  always @(posedge sda) if (scl) begin busy = 1'b0; sda_oe_n = 1'b1; end
  always @(posedge scl) if (busy) r = r + 1;
  // change well after scl falls and off the clock edge, so no false
  // start or stop is seen and no sample races the change
  always @(negedge scl)
  begin
    #190;
    if (busy)
      sda_oe_n = (r == 8) ? nak :
        (r > 8 && r < 27 && !nak && (r - 9) % 9 < 8) ?
        data[15 - (r - 9) / 9 * 8 - (r - 9) % 9] : 1'b1;
  end
endmodule // ecl_eeprom_model

// ===== tb/ecl_loader_assertions.sv
/* port checker of ecl_loader.
   assumes the bind below; sees ports only. */
`timescale 1ns/100ps
module ecl_loader_assertions
#(
  parameter int LOAD_CYC = 2000
)
(
  // ports watched
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_LOAD_REQ_N,
  input wire logic O_LOAD_DONE_N,
  input wire logic O_PRIMARY,
  input wire logic I_SCL,
  input wire logic I_SDA,
  input wire logic O_SCL_OE_N,
  input wire logic O_SDA_OE_N,
  input wire logic O_SDA_FILT,
  input wire logic O_CFG_VALID
);
  int         req_ff;
  int         lo_ff;
  int         hi_ff;
  logic [1:0] run_ff;
  logic [5:0] hist_ff;
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      req_ff  <= 0;
      lo_ff   <= 0;
      hi_ff   <= 0;
      run_ff  <= 2'h0;
      hist_ff <= 6'h3f;
    end
    else
    begin
      run_ff  <= (run_ff == 2'h3) ? 2'h3 : run_ff + 2'h1;
      req_ff  <= (!I_LOAD_REQ_N || req_ff != 0) ? req_ff + 1 : 0;
      lo_ff   <= O_SCL_OE_N ? 0 : lo_ff + 1;
      hi_ff   <= I_SCL ? hi_ff + 1 : 0;
      hist_ff <= {hist_ff[4:0], I_SDA};
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  done_hold_a: assert property
    (!O_LOAD_DONE_N |=> !O_LOAD_DONE_N) else $error("done released");
  done_time_a: assert property
    ($fell(O_LOAD_DONE_N) |-> req_ff >= LOAD_CYC) else $error("done early");
  sec_quiet_a: assert property
    (run_ff && !O_PRIMARY |-> O_SCL_OE_N && O_SDA_OE_N && O_LOAD_DONE_N)
    else $error("secondary drove");
  strap_hold_a: assert property
    (run_ff == 2'h3 |=> $stable(O_PRIMARY)) else $error("mode changed");
  scl_low_a: assert property
    ($rose(O_SCL_OE_N) |-> lo_ff >= ecl_pkg::SCL_LOW_CYC)
    else $error("scl low short");
  scl_high_a: assert property
    ($fell(O_SCL_OE_N) |-> hi_ff >= ecl_pkg::SCL_HIGH_CYC)
    else $error("scl high short");
  sda_filt_a: assert property
    ($changed(O_SDA_FILT) |-> (O_SDA_FILT
      ? |(hist_ff[5:2] & hist_ff[4:1] & hist_ff[3:0])
      : |(~hist_ff[5:2] & ~hist_ff[4:1] & ~hist_ff[3:0])))
    else $error("spike passed");
  valid_pulse_a: assert property
    (O_CFG_VALID |=> !O_CFG_VALID) else $error("valid too long");
  cover property ($fell(O_LOAD_DONE_N));
  cover property (O_CFG_VALID);
  cover property ($changed(O_SDA_FILT));
endmodule // ecl_loader_assertions
bind ecl_loader ecl_loader_assertions #(.LOAD_CYC(LOAD_CYC)) u_chk (
  .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_LOAD_REQ_N(I_LOAD_REQ_N),
  .O_LOAD_DONE_N(O_LOAD_DONE_N), .O_PRIMARY(O_PRIMARY), .I_SCL(I_SCL),
  .I_SDA(I_SDA), .O_SCL_OE_N(O_SCL_OE_N), .O_SDA_OE_N(O_SDA_OE_N),
  .O_SDA_FILT(O_SDA_FILT), .O_CFG_VALID(O_CFG_VALID));

// ===== tb/testbench.sv
/* testbench of ecl_loader with the eeprom model.
   assumes a shortened load count of 2000 cycles. */
`timescale 1ns/100ps
module testbench;
  logic        clk, rst_n, req_n, nak, tb_sda_n, sf_low;
  logic [2:0]  strap, s;
  logic [15:0] data;
  logic [7:0]  got [2];
  wire         scl, sda, scl_oe_n, sda_oe_n, ee_oe_n, done_n, prim;
  wire         filt, valid, sclf;
  wire  [7:0]  cfg;
  int          errors, n_checks, nb, cyc;
  assign scl = scl_oe_n;
  assign sda = sda_oe_n & ee_oe_n & tb_sda_n;
  ecl_loader #(.LOAD_CYC(2000), .LOAD_BYTES(2)) u_ecl_loader (
    .I_CLK(clk), .I_RST_N(rst_n), .I_MODE_STRAP(strap),
    .I_LOAD_REQ_N(req_n), .O_LOAD_DONE_N(done_n), .O_PRIMARY(prim),
    .I_SCL(scl), .I_SDA(sda), .O_SCL_OE_N(scl_oe_n),
    .O_SDA_OE_N(sda_oe_n), .O_SCL_FILT(sclf), .O_SDA_FILT(filt),
    .O_CFG_DATA(cfg), .O_CFG_VALID(valid));
  ecl_eeprom_model u_ecl_eeprom_model (.scl(scl), .sda(sda),
    .data(data), .nak(nak), .sda_oe_n(ee_oe_n));
  initial begin clk = 1'b0; forever #20 clk = ~clk; end
  task chk1(input string w, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin errors++; $display("BAD %s exp %h got %h", w, e, g); end
  endtask
  task chk8(input string w, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin errors++; $display("BAD %s exp %h got %h", w, e, g); end
  endtask
  task wrap_up;
    if (errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task run_reset(input logic [2:0] m, input logic k);
    @(posedge clk);
    rst_n <= 1'b0; strap <= m; nak <= k; req_n <= 1'b1;
    data <= 16'($urandom);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // straps stay at m until they are taken, then change at random
    repeat (4) @(posedge clk);
    strap <= 3'($urandom);
  endtask
  // pull sda low n cycles; e is the lowest filtered level expected
  task glitch(input int n, input logic e);
    logic m;
    m = 1'b1;
    tb_sda_n <= 1'b0;
    for (int i = 0; i < 12; i++)
    begin
      @(negedge clk) m = m & filt;
      @(posedge clk) if (i == n - 1) tb_sda_n <= 1'b1;
    end
    chk1("sda_filt", e, m);
  endtask
  task wait_n(input int n); repeat (n) @(negedge clk); endtask
  initial
  begin
    errors = 0; n_checks = 0; tb_sda_n = 1'b1; rst_n = 1'b0;
    req_n = 1'b1; strap = 3'h1; nak = 1'b0; data = 16'h0000;
    s = 3'($urandom(32'ha6e17f03));
    run_reset(ecl_pkg::STRAP_LEVEL_ONE, 1'b0);
    glitch(1, 1'b1);
    glitch(8, 1'b0);
    req_n <= 1'b0;
    nb = 0; cyc = 0; sf_low = 1'b0;
    while (done_n !== 1'b0 && cyc <= 9000)
    begin
      @(negedge clk) cyc++;
      if (sclf === 1'b0) sf_low = 1'b1;
      if (valid === 1'b1 && nb < 2) begin got[nb] = cfg; nb++; end
    end
    chk1("done_n", 1'b0, done_n);
    chk1("load_time", 1'b1, cyc >= 2000);
    chk1("scl_filt", 1'b1, sf_low);
    for (int i = 0; i < 2; i++)
      chk8("cfg", data[15 - 8 * i -: 8], got[i]);
    wait_n(100);
    chk1("done_n", 1'b0, done_n);
    chk1("primary", 1'b1, prim);
    run_reset(ecl_pkg::STRAP_LEVEL_ONE, 1'b1);
    req_n <= 1'b0;
    wait_n(6000);
    chk1("done_n", 1'b1, done_n);
    chk1("sda_oe_n", 1'b1, sda_oe_n);
    // a host that wins arbitration during the address makes the load fail
    run_reset(ecl_pkg::STRAP_LEVEL_ONE, 1'b0);
    req_n <= 1'b0;
    repeat (100) @(posedge clk);
    tb_sda_n <= 1'b0;
    repeat (200) @(posedge clk);
    tb_sda_n <= 1'b1;
    wait_n(3000);
    chk1("done_n", 1'b1, done_n);
    chk1("scl_oe_n", 1'b1, scl_oe_n);
    if (s == 3'h1) s = ecl_pkg::STRAP_LEVEL_TWO;
    run_reset(s, 1'b0);
    glitch(8, 1'b0);
    req_n <= 1'b0;
    wait_n(4000);
    chk1("done_n", 1'b1, done_n);
    chk1("primary", 1'b0, prim);
    chk1("scl_oe_n", 1'b1, scl_oe_n);
    wrap_up;
  end
endmodule // testbench
